// >>> common/spi_shifter_params.svh
// spi_shifter_params.svh: widths, encodings and timing counts of the shifter
// assumes inclusion by the package and the design files by bare name
`ifndef SPI_SHIFTER_PARAMS_SVH
`define SPI_SHIFTER_PARAMS_SVH

// ============================================================
// data and buffer shape
`define SPI_BYTE_W      8
`define SPI_BUF_DEPTH   2
`define SPI_BUF_FULL    2'h2

// ============================================================
// rate select encodings {rate_select_hi, rate_select_lo}
`define SPI_RATE_DIVIDE_BY_TWO   2'h0
`define SPI_RATE_DIV8   2'h1
`define SPI_RATE_DIVIDE_BY_THIRTY_TWO  2'h2
`define SPI_RATE_DIVIDE_BY_ONE_TWENTY_EIGHT 2'h3

// bit times in bus cycles for each rate
`define SPI_BIT_CYC_DIVIDE_BY_TWO   8'h02
`define SPI_BIT_CYC_DIV8   8'h08
`define SPI_BIT_CYC_DIVIDE_BY_THIRTY_TWO  8'h20
`define SPI_BIT_CYC_DIVIDE_BY_ONE_TWENTY_EIGHT 8'h80

// ============================================================
// frame counts
`define SPI_LAST_HALF   4'hf
`define SPI_LAST_BIT    4'h7
`define SPI_TX_EMPTY_MAX_CYC 2

`endif

// >>> common/spi_shifter_pkg.sv
// spi_shifter_pkg: types shared by the shifter and its receive buffer
// assumes spi_shifter_params.svh sits on the include path
`include "spi_shifter_params.svh"

package spi_shifter_pkg;

  // ============================================================
  // basic types
  typedef logic [`SPI_BYTE_W-1:0] byte_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_SHIFT = 2'b10,
    ST_DRAIN = 2'b11
  } xfer_st_t;

  // ============================================================
  // whole state of the shifter
  typedef struct packed {
    xfer_st_t   st;
    byte_t      sh;
    byte_t      txb;
    logic       tx_full;
    byte_t      rxd;
    logic       rx_full;
    logic       ovf;
    logic       rd_armed;
    logic [5:0] div_cnt;
    logic [3:0] phase;
    logic       samp;
    logic [1:0] cap_q;
    logic       sck_out;
    logic [1:0] sck_sy;
    logic [1:0] ss_sy;
    logic [1:0] mosi_sy;
    logic [1:0] miso_sy;
    logic       sck_d;
    logic       ss_d;
  } shifter_state_t;

  // whole state of the two-entry buffer
  typedef struct packed {
    logic [`SPI_BUF_DEPTH-1:0][`SPI_BYTE_W-1:0] mem;
    logic       wr;
    logic       rd;
    logic [1:0] cnt;
  } buf_state_t;

endpackage : spi_shifter_pkg

// >>> common/spi_byte_if.sv
// spi_byte_if: valid/ready byte stream between shifter and buffer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none

interface spi_byte_if;
  import spi_shifter_pkg::*;
  logic  valid;
  logic  ready;
  byte_t data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : spi_byte_if

`default_nettype wire

// >>> design/spi_two_entry_buf.sv
// spi_two_entry_buf: two-entry byte buffer with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "spi_shifter_params.svh"

module spi_two_entry_buf
  import spi_shifter_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // stream sides
  spi_byte_if.snk   in_port,
  spi_byte_if.src   out_port
);

  buf_state_t s;
  buf_state_t next_s;
  logic       push;
  logic       pop;

  // ============================================================
  // handshakes; read data is a register selected by the read pointer
  assign in_port.ready  = (s.cnt != `SPI_BUF_FULL);
  assign out_port.valid = (s.cnt != 2'h0);
  assign out_port.data  = s.mem[s.rd];
  assign push = in_port.valid && in_port.ready;
  assign pop  = out_port.valid && out_port.ready;

  // next state
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_port.data;
      next_s.wr        = ~s.wr;
    end
    if (pop) begin
      next_s.rd = ~s.rd;
    end
    next_s.cnt = 2'(s.cnt + {1'b0, push} - {1'b0, pop});
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ============================================================
  // a full buffer never claims room
  property p_full_refuses;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (s.cnt == `SPI_BUF_FULL) |-> !in_port.ready;
  endproperty
  a_full_refuses: assert property (p_full_refuses)
    else $error("buffer full yet ready");

  // a byte pushed into an empty buffer is offered next cycle
  property p_first_through;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (push && s.cnt == 2'h0) |=>
        (out_port.valid && out_port.data == $past(in_port.data));
  endproperty
  a_first_through: assert property (p_first_through)
    else $error("pushed byte not offered");

endmodule : spi_two_entry_buf

`default_nettype wire

// >>> design/spi_master_slave_shifter.sv
// spi_master_slave_shifter: full-duplex serial shifter, master or slave
// assumes pins arrive asynchronous; control bits are plain ports from the
// processor side, read/write strobes are one-cycle pulses on core_clk_i
//
// Operation
// - master_select_bit set means master, clear means slave.
// - master write to data starts transfer; idle shifter loads it, empty flag set.
// - rate select bits set baud divider; master clock drives slave shifting.
// - byte in while byte out; at end set full and copy byte together.
// - full flag clears after status read seeing it, then data read.
// - any data write clears the transmit empty flag.
// - slave takes its shift clock from the serial clock pin.
// - slave moves a complete byte to receive register and sets full.
// - slave accepts any clock up to bus rate, ignoring rate select; two-stage pin sampling keeps the usable rate below bus rate.
// - byte written during slave transfer waits in buffer until transfer ends.
// - slave starts on first clock edge if phase set, select fall otherwise.
// - slave drives its data out only while selected.
// - phase zero slave presents most significant bit when select falls.
// - phase one: first clock edge starts the transfer; select may stay low.
// - no transmit buffer load into shift register once slave transfer began.
// - master phase zero: clock idle first half; phase one: starts with edge.
// - divider runs only when module enable and master select are set.
// - master write to transfer start within one bit time.
// - unread receive register on next byte: set overflow, keep old byte.
// - idle shifter sets transmit empty within two cycles after loading.
`timescale 1ns/1ps
`default_nettype none
`include "spi_shifter_params.svh"

module spi_master_slave_shifter
  import spi_shifter_pkg::*;
(
  // clock and reset
  input  wire logic  core_clk_i,
  input  wire logic  rst_n_i,
  // control bits
  input  wire logic  module_enable_bit_i,
  input  wire logic  master_select_bit_i,
  input  wire logic  clock_phase_bit_i,
  input  wire logic  clock_polarity_bit_i,
  input  wire logic  rate_select_hi_i,
  input  wire logic  rate_select_lo_i,
  // processor access
  input  wire logic  [7:0] tx_data_i,
  input  wire logic  tx_write_i,
  input  wire logic  status_read_i,
  input  wire logic  data_read_i,
  output logic [7:0] rx_data_o,
  output logic       rx_full_flag_o,
  output logic       tx_empty_flag_o,
  output logic       overflow_flag_o,
  output logic       busy_o,
  // serial pins
  input  wire logic  serial_clock_pin_i,
  output logic       serial_clock_pin_o,
  output logic       serial_clock_pin_oe_o,
  input  wire logic  slave_select_n_i,
  input  wire logic  mosi_i,
  output logic       mosi_o,
  output logic       mosi_oe_o,
  input  wire logic  miso_i,
  output logic       miso_o,
  output logic       miso_oe_o
);

  // ============================================================
  // state and combinational terms
  shifter_state_t s;
  shifter_state_t next_s;
  logic           run_m;
  logic           run_s;
  logic           tick;
  logic           lead;
  logic           trail;
  logic           ss_fall;
  logic           samp_e;
  logic           shift_e;
  logic           byte_done;
  byte_t          byte_in;
  logic           rx_fill;
  logic [1:0]     rate;

  spi_byte_if rx_in ();
  spi_byte_if rx_out ();

  // half bit terminal count from the bit time of the selected rate
  function automatic logic [5:0] half_end(input logic [1:0] r);
    logic [7:0] b;
    unique case (r)
      `SPI_RATE_DIVIDE_BY_TWO:   b = `SPI_BIT_CYC_DIVIDE_BY_TWO;
      `SPI_RATE_DIV8:   b = `SPI_BIT_CYC_DIV8;
      `SPI_RATE_DIVIDE_BY_THIRTY_TWO:  b = `SPI_BIT_CYC_DIVIDE_BY_THIRTY_TWO;
      `SPI_RATE_DIVIDE_BY_ONE_TWENTY_EIGHT: b = `SPI_BIT_CYC_DIVIDE_BY_ONE_TWENTY_EIGHT;
    endcase
    half_end = 6'((b >> 1) - 8'h01);
  endfunction : half_end

  assign rate  = {rate_select_hi_i, rate_select_lo_i};
  assign run_m = module_enable_bit_i && master_select_bit_i;
  assign run_s = module_enable_bit_i && !master_select_bit_i;

  // ============================================================
  // receive buffer: absorbs a finished byte while the register fills
  spi_two_entry_buf u_rx_buf (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .in_port    (rx_in),
    .out_port   (rx_out)
  );

  // a byte is offered only when nothing unread blocks it
  assign rx_in.valid  = byte_done && !s.rx_full && !s.ovf;
  assign rx_in.data   = byte_in;
  assign rx_out.ready = !s.rx_full && !s.ovf;
  assign rx_fill      = rx_out.valid && rx_out.ready;

  // ============================================================
  // next state
  always_comb begin
    next_s    = s;
    tick      = 1'b0;
    lead      = 1'b0;
    trail     = 1'b0;
    ss_fall   = 1'b0;
    samp_e    = 1'b0;
    shift_e   = 1'b0;
    byte_done = 1'b0;
    byte_in   = {s.sh[6:0], s.samp};

    // pin synchronisers; only the second stage is looked at
    next_s.sck_sy  = {s.sck_sy[0], serial_clock_pin_i};
    next_s.ss_sy   = {s.ss_sy[0], slave_select_n_i};
    next_s.mosi_sy = {s.mosi_sy[0], mosi_i};
    next_s.miso_sy = {s.miso_sy[0], miso_i};
    next_s.sck_d   = s.sck_sy[1];
    next_s.ss_d    = s.ss_sy[1];
    next_s.cap_q   = {s.cap_q[0], 1'b0};

    // free-running divider, stopped to save power when not master
    if (run_m) begin
      tick = (s.div_cnt == half_end(rate));
      next_s.div_cnt = tick ? 6'h00 : 6'(s.div_cnt + 6'h01);
    end else begin
      next_s.div_cnt = 6'h00;
    end

    // slave edge detection on synchronised levels
    lead  = (s.sck_sy[1] != s.sck_d) &&
            (s.sck_sy[1] != clock_polarity_bit_i);
    trail = (s.sck_sy[1] != s.sck_d) &&
            (s.sck_sy[1] == clock_polarity_bit_i);
    ss_fall = !s.ss_sy[1] && s.ss_d;
    samp_e  = clock_phase_bit_i ? trail : lead;
    shift_e = clock_phase_bit_i ? lead : trail;

    // receive register read sequence; a later fill wins
    if (status_read_i && (s.rx_full || s.ovf)) begin
      next_s.rd_armed = 1'b1;
    end
    if (data_read_i && s.rd_armed) begin
      next_s.rx_full  = 1'b0;
      next_s.ovf      = 1'b0;
      next_s.rd_armed = 1'b0;
    end

    if (!module_enable_bit_i) begin
      // disabled: hold the link quiet, keep queued data
      next_s.st      = ST_IDLE;
      next_s.phase   = 4'h0;
      next_s.sck_out = clock_polarity_bit_i;
    end else if (master_select_bit_i) begin
      // ------------------------------------------------ master
      unique case (s.st)
        ST_IDLE: begin
          next_s.sck_out = clock_polarity_bit_i;
          if (s.tx_full) begin
            next_s.sh      = s.txb;
            next_s.tx_full = 1'b0;
            next_s.st      = ST_ARMED;
          end
        end
        ST_ARMED: begin
          // start aligned to the divider, so the wait is under a bit
          if (tick) begin
            next_s.st      = ST_SHIFT;
            next_s.phase   = 4'h0;
            next_s.sck_out = clock_polarity_bit_i ^ clock_phase_bit_i;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            next_s.phase   = 4'(s.phase + 4'h1);
            next_s.sck_out = clock_polarity_bit_i ^
                             (~s.phase[0] ^ clock_phase_bit_i);
            if (!s.phase[0]) begin
              next_s.cap_q[0] = 1'b1;
            end else if (s.phase == `SPI_LAST_HALF) begin
              next_s.sh      = byte_in;
              next_s.st      = ST_DRAIN;
              next_s.sck_out = clock_polarity_bit_i;
            end else begin
              next_s.sh = {s.sh[6:0], s.samp};
            end
          end
        end
        ST_DRAIN: begin
          // the last late sample must land before the byte is handed on
          if (!s.cap_q[1]) begin
            byte_done = 1'b1;
            byte_in   = s.sh;
            next_s.st = ST_IDLE;
          end
        end
      endcase
      // miso is seen two cycles late, so each sample lands two cycles
      // after its edge; at the fastest rate the shift has moved already
      if (s.cap_q[1]) begin
        if (s.st == ST_SHIFT && s.phase[0]) begin
          next_s.samp = s.miso_sy[1];
        end else begin
          next_s.sh[0] = s.miso_sy[1];
        end
      end
    end else begin
      // ------------------------------------------------ slave
      // rate select plays no part here: edges come from the pin, and
      // two-stage sampling limits the usable rate below the bus clock
      next_s.sck_out = clock_polarity_bit_i;
      unique case (s.st)
        ST_IDLE: begin
          // an idle slave preloads, so msb is already on its output
          if (s.tx_full) begin
            next_s.sh      = s.txb;
            next_s.tx_full = 1'b0;
          end
          if (!clock_phase_bit_i && ss_fall) begin
            next_s.st    = ST_SHIFT;
            next_s.phase = 4'h0;
          end else if (clock_phase_bit_i && lead && !s.ss_sy[1]) begin
            next_s.st    = ST_SHIFT;
            next_s.phase = 4'h0;
          end
        end
        ST_SHIFT: begin
          // no buffer load while shifting; writes wait in the buffer
          if (s.ss_sy[1]) begin
            next_s.st = ST_IDLE;
          end else if (samp_e) begin
            next_s.samp = s.mosi_sy[1];
            if (s.phase == `SPI_LAST_BIT) begin
              byte_done = 1'b1;
              byte_in   = {s.sh[6:0], s.mosi_sy[1]};
              next_s.sh = byte_in;
              next_s.st = ST_IDLE;
            end else begin
              next_s.phase = 4'(s.phase + 4'h1);
            end
          end else if (shift_e) begin
            next_s.sh = {s.sh[6:0], s.samp};
          end
        end
        default: begin
          next_s.st = ST_IDLE;
        end
      endcase
    end

    // unread byte blocks a new one, which is dropped
    if (byte_done && (s.rx_full || s.ovf || !rx_in.ready)) begin
      next_s.ovf = 1'b1;
    end
    // fill from the buffer: flag and data in the same step
    if (rx_fill) begin
      next_s.rxd     = rx_out.data;
      next_s.rx_full = 1'b1;
    end
    // a write refills the transmit buffer and wins over a load
    if (tx_write_i) begin
      next_s.txb     = tx_data_i;
      next_s.tx_full = 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ============================================================
  // outputs
  assign rx_data_o             = s.rxd;
  assign rx_full_flag_o        = s.rx_full;
  assign tx_empty_flag_o       = !s.tx_full;
  assign overflow_flag_o       = s.ovf;
  assign busy_o                = (s.st != ST_IDLE);
  assign serial_clock_pin_o    = s.sck_out;
  assign serial_clock_pin_oe_o = run_m;
  assign mosi_o                = s.sh[7];
  assign mosi_oe_o             = run_m;
  assign miso_o                = s.sh[7];
  // select is seen two cycles late, so release lags the pin by two
  assign miso_oe_o             = run_s && !s.ss_sy[1];

  // ============================================================
  // checks
  property p_write_clears_empty;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      tx_write_i |=> !tx_empty_flag_o;
  endproperty
  a_write_clears_empty: assert property (p_write_clears_empty)
    else $error("write left transmit empty set");

  sequence s_status_seen;
    status_read_i && rx_full_flag_o && !data_read_i;
  endsequence
  sequence s_data_read;
    data_read_i && !rx_fill;
  endsequence
  property p_rx_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      s_status_seen ##1 s_data_read |=> !rx_full_flag_o;
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("full flag not cleared by read pair");

  property p_rx_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (rx_full_flag_o && !s.rd_armed && !status_read_i) |=> rx_full_flag_o;
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("full flag cleared without status read");

  property p_fill_copies;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      rx_fill |=> (rx_full_flag_o && rx_data_o == $past(rx_out.data));
  endproperty
  a_fill_copies: assert property (p_fill_copies)
    else $error("receive flag and data not set together");

  property p_overflow_keeps;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (byte_done && rx_full_flag_o && !rx_fill) |=>
        (overflow_flag_o && $stable(rx_data_o));
  endproperty
  a_overflow_keeps: assert property (p_overflow_keeps)
    else $error("overflow lost or old byte replaced");

  property p_idle_reload;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (tx_write_i && s.st == ST_IDLE && module_enable_bit_i) ##1
        (!tx_write_i && module_enable_bit_i) |=> tx_empty_flag_o;
  endproperty
  a_idle_reload: assert property (p_idle_reload)
    else $error("transmit empty not set again in two cycles");

  property p_fast_start;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (run_m && s.st == ST_ARMED && rate == `SPI_RATE_DIVIDE_BY_TWO) |=>
        (s.st == ST_SHIFT);
  endproperty
  a_fast_start: assert property (p_fast_start)
    else $error("master start later than one bit");

  property p_first_level;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (run_m && s.st == ST_ARMED && tick) |=>
        (serial_clock_pin_o == (clock_polarity_bit_i ^ clock_phase_bit_i));
  endproperty
  a_first_level: assert property (p_first_level)
    else $error("wrong serial clock level at start");

  property p_miso_released;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      s.ss_sy[1] |-> !miso_oe_o;
  endproperty
  a_miso_released: assert property (p_miso_released)
    else $error("unselected slave drives data out");

  property p_slave_start;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (run_s && s.st == ST_IDLE && !clock_phase_bit_i && ss_fall) |=>
        (s.st == ST_SHIFT &&
         miso_o == $past(s.tx_full ? s.txb[7] : s.sh[7]));
  endproperty
  a_slave_start: assert property (p_slave_start)
    else $error("slave did not start on select fall");

  property p_slave_holds_buffer;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (run_s && s.st == ST_SHIFT && s.tx_full && !s.ss_sy[1]) |=>
        !tx_empty_flag_o;
  endproperty
  a_slave_holds_buffer: assert property (p_slave_holds_buffer)
    else $error("buffer loaded during slave transfer");

  property p_master_len;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (byte_done && run_m) |-> (s.st == ST_DRAIN && s.phase == 4'h0);
  endproperty
  a_master_len: assert property (p_master_len)
    else $error("master byte not sixteen half bits");

  property p_mode_pins;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      run_m |-> (serial_clock_pin_oe_o && mosi_oe_o && !miso_oe_o);
  endproperty
  a_mode_pins: assert property (p_mode_pins)
    else $error("master pin directions wrong");

endmodule : spi_master_slave_shifter

`default_nettype wire

// >>> test/spi_partner_slave.sv
// spi_partner_slave: behavioural peripheral on the far side of the link
// assumes the bench drives its select and the byte it answers with
`timescale 1ns/1ps
`default_nettype none

module spi_partner_slave (
  // serial side
  input  wire logic       sck_i,
  input  wire logic       ss_n_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  // setup
  input  wire logic       pol_i,
  input  wire logic       pha_i,
  input  wire logic [7:0] tx_byte_i,
  output logic      [7:0] rx_byte_o
);
  logic [7:0] sh;

  // ============================================================
  // select fall loads the answer; phase zero shows the msb at once
  initial miso_o = 1'b1;
  always @(negedge ss_n_i) begin
    sh = tx_byte_i;
    if (!pha_i) miso_o = sh[7];
  end

  // a released line shows the inverse, never a stale level
  always @(posedge ss_n_i) miso_o = ~miso_o;

  // data changes just after the shift edge, inside the fastest half bit
  always @(sck_i) if (!ss_n_i) begin
    if ((sck_i != pol_i) ^ pha_i) rx_byte_o = {rx_byte_o[6:0], mosi_i};
    else if (pha_i) begin
      miso_o <= #1 sh[7];
      sh = sh << 1;
    end else begin
      sh = sh << 1;
      miso_o <= #1 sh[7];
    end
  end
endmodule : spi_partner_slave

`default_nettype wire

// >>> test/testbench.sv
// testbench: self-checking bench for the master/slave serial shifter
// assumes spi_partner_slave stands on the link in master mode
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import spi_shifter_pkg::*;
  logic  clk = 1'b0, rst_n = 1'b0, en = 1'b0, mst = 1'b0;
  logic  pha = 1'b0, pol = 1'b0, wr = 1'b0, srd = 1'b0, drd = 1'b0;
  logic  [1:0] rate = 2'h0;
  byte_t wdat = 8'h00, prt_tx = 8'h00, got, prt_rx, rxd, a, b, p;
  logic  rxf, txe, ovf, busy, sck_o, sck_oe, mosi_o, mosi_oe, miso_o;
  logic  miso_oe, prt_miso, sck_tb = 1'b0, mosi_tb = 1'b0;
  logic  dss_n = 1'b1, pss_n = 1'b1;
  int    fails = 0, tests_run = 0, seed = 32'h77f9, n;
  // pin levels from each party's enable
  wire   sck = sck_oe ? sck_o : sck_tb;
  wire   mosi = mosi_oe ? mosi_o : mosi_tb;
  wire   miso = miso_oe ? miso_o : prt_miso;

  // ============================================================
  // clock and parts
  always #2 clk = ~clk;
  spi_master_slave_shifter i_spi_master_slave_shifter (
    .core_clk_i(clk), .rst_n_i(rst_n), .module_enable_bit_i(en),
    .master_select_bit_i(mst), .clock_phase_bit_i(pha),
    .clock_polarity_bit_i(pol), .rate_select_hi_i(rate[1]),
    .rate_select_lo_i(rate[0]), .tx_data_i(wdat), .tx_write_i(wr),
    .status_read_i(srd), .data_read_i(drd), .rx_data_o(rxd),
    .rx_full_flag_o(rxf), .tx_empty_flag_o(txe), .overflow_flag_o(ovf),
    .busy_o(busy), .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe_o(sck_oe), .slave_select_n_i(dss_n),
    .mosi_i(mosi), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso),
    .miso_o(miso_o), .miso_oe_o(miso_oe));
  spi_partner_slave i_spi_partner_slave (.sck_i(sck), .ss_n_i(pss_n),
    .mosi_i(mosi), .miso_o(prt_miso), .pol_i(pol), .pha_i(pha),
    .tx_byte_i(prt_tx), .rx_byte_o(prt_rx));

  // ============================================================
  // helpers
  function automatic int bitc(logic [1:0] r);
    return 2 << (2 * r);
  endfunction : bitc
  task automatic step(int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic chk_bit(logic g, logic e, string m);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk_bit
  task automatic chk_byte(byte_t g, byte_t e, string m);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t %s %h %h", $time, m, g, e);
    end
  endtask : chk_byte
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask : pulse
  task automatic wr_byte(byte_t v);
    wdat = v;
    pulse(wr);
    chk_bit(txe, 1'b0, "empty flag after write");
  endtask : wr_byte
  task automatic rd_pair();
    pulse(srd);
    pulse(drd);
    step();
    chk_bit(rxf, 1'b0, "full flag clear");
  endtask : rd_pair
  // mode bits change only while the block is off
  task automatic setup(logic m, logic ph, logic po, logic [1:0] r);
    en = 1'b0;
    step();
    mst = m;
    pha = ph;
    pol = po;
    rate = r;
    step();
    en = 1'b1;
    step(3);
  endtask : setup
  task automatic mxfer(byte_t tb, byte_t pb);
    prt_tx = pb;
    pss_n = 1'b0;
    step(2);
    wr_byte(tb);
    for (n = 0; busy !== 1'b1 && n < 300; n++) step();
    chk_bit(n <= bitc(rate) + 3, 1'b1, "start latency");
    chk_bit(txe, 1'b1, "empty after load");
    for (n = 0; busy !== 1'b0 && n < 3000; n++) step();
    step(3);
    pss_n = 1'b1;
  endtask : mxfer
  // bench acts as external master; optional write in mid byte
  task automatic sxfer(byte_t m, logic wmid, byte_t w);
    dss_n = 1'b0;
    mosi_tb = m[7];
    step(8);
    chk_bit(miso_oe, 1'b1, "selected slave drives");
    for (int i = 7; i >= 0; i--) begin
      sck_tb = ~pol;
      if (pha) mosi_tb = m[i];
      else got[i] = miso;
      if (wmid && i == 4) wr_byte(w);
      step(8);
      sck_tb = pol;
      if (pha) got[i] = miso;
      else if (i > 0) mosi_tb = m[i-1];
      step(8);
    end
    dss_n = 1'b1;
    step(8);
    chk_bit(miso_oe, 1'b0, "unselected slave quiet");
    chk_byte(rxd, m, "slave rx byte");
    rd_pair();
  endtask : sxfer
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  // ============================================================
  // main sequence: reset, master rates, overflow, slave phases
  initial begin
    step(12);
    rst_n = 1'b1;
    step(3);
    chk_bit(txe, 1'b1, "reset empty");
    chk_bit(rxf | ovf | busy, 1'b0, "reset flags");
    for (int r = 0; r < 4; r++) begin
      n = $random(seed);
      setup(1'b1, n[0], n[1], r[1:0]);
      b = r == 0 ? 8'h80 : 8'($random(seed));
      p = r == 0 ? 8'h01 : 8'($random(seed));
      mxfer(b, p);
      chk_byte(rxd, p, "master rx byte");
      chk_byte(prt_rx, b, "partner rx byte");
      chk_bit(sck, pol, "clock idle level");
      chk_bit(sck_oe & mosi_oe, 1'b1, "master drives pins");
      pulse(drd);
      step();
      chk_bit(rxf, 1'b1, "lone data read");
      rd_pair();
    end
    mxfer(8'h3c, 8'ha5);
    mxfer(8'hc3, 8'h5a);
    chk_bit(ovf, 1'b1, "overflow set");
    chk_byte(rxd, 8'ha5, "old byte kept");
    rd_pair();
    chk_bit(ovf, 1'b0, "overflow clear");
    for (int ph = 0; ph < 2; ph++) begin
      setup(1'b0, ph[0], 1'b0, 2'h3);
      chk_bit(sck_oe | mosi_oe, 1'b0, "slave pins are inputs");
      a = 8'($random(seed));
      wr_byte(a);
      step(2);
      chk_bit(txe, 1'b1, "idle slave load");
      b = 8'($random(seed));
      sxfer(b, 1'b0, 8'h00);
      chk_byte(got, a, "slave tx byte");
      p = 8'($random(seed));
      sxfer(8'h5a, 1'b1, p);
      chk_byte(got, b, "resent shift byte");
      sxfer(8'h81, 1'b0, 8'h00);
      chk_byte(got, p, "held byte sent next");
    end
    final_report();
  end

  // watchdog: the run needs well under this many cycles
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule : testbench

`default_nettype wire
